// file: hw/pst_regs.svh
// Summary of operation
// - reserved status bits 1.10:7 always read back as zero
// - gated_write_bit fields change only while override enable 16.15 is one
// - status bit 1.6 advertises management_frame preamble suppression capability
// - bit 1.6 resets to zero and is a gated_write_bit
// - negotiation complete bit 1.5 held zero while negotiation is disabled
// - bit 1.5 sets only when the negotiation machine completes
// - bit 1.5 is a latch_high_flag released by a register read or by disabling negotiation
// - received link code word remote fault bit sets status bit 1.4
// - one remote fault latch_high_flag seen as 1.4 and 17.1, read clears
// - bit 5.13 is a non-latching remote fault copy from each code word
// - first read returns latched event, next read the present condition
// - negotiation ability bit 1.3 always reads one
// - link status 1.2 is a latch_low_flag mirrored in bit 17.0
// - link monitor result from the active receiver drives link status
// - jabber control 18.5 zero disables detection and forces bit 1.1 zero
// - with 18.5 one a jabber condition sets the flag, else unchanged
// - jabber latch_high_flag seen as 1.1 and 17.2, read of either clears
// - extended capability bit 1.0 always reads one
// - registers 2 and 3 form the 32-bit device identifier
// - identifier bits always readable, writable only with override enable
// - register 2 holds identifier bits 3 to 18, bit 3 in 2.15
// - status register sits at management address 0x01, reset restores defaults
`ifndef PST_REGS_SVH
`define PST_REGS_SVH

// management register addresses
`define PST_ADDR_STATUS    5'h01
`define PST_ADDR_ID_HI     5'h02
`define PST_ADDR_ID_LO     5'h03
`define PST_ADDR_LP_ABIL   5'h05
`define PST_ADDR_FAST_STAT 5'h11

// status register field positions
`define PST_BIT_RESV_HI    10
`define PST_BIT_RESV_LO    7
`define PST_BIT_PRE_SUP    6
`define PST_BIT_AN_DONE    5
`define PST_BIT_RFAULT     4
`define PST_BIT_AN_ABLE    3
`define PST_BIT_LINK       2
`define PST_BIT_JABBER     1
`define PST_BIT_EXT_CAP    0

// partner ability and fast status field positions
`define PST_BIT_LP_RFAULT  13
`define PST_BIT_FS_JABBER  2
`define PST_BIT_FS_RFAULT  1
`define PST_BIT_FS_LINK    0

// reset values
`define PST_RST_PRE_SUP    1'b0
`define PST_RST_RESV       4'h0

// frame timing counts, in management clock bits
`define PST_PREAMBLE_BITS  6'd32
`define PST_HDR_LAST       5'd11
`define PST_TA_LAST        5'd1
`define PST_DATA_LAST      5'd15

// frame opcodes
`define PST_OP_READ        2'b10
`define PST_OP_WRITE       2'b01

`endif

// file: hw/pst_pkg.sv
package pst_pkg;

  // management frame receiver states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_HDR   = 3'b010,
    ST_TA    = 3'b011,
    ST_DATA  = 3'b100
  } pst_state_type;

endpackage

// file: hw/pst_sync.sv
`timescale 1ns/100ps

// two flip-flop synchroniser for pin inputs
module pst_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule // pst_sync

// file: hw/pst_status_regs.sv
`timescale 1ns/100ps
`include "pst_regs.svh"

// status and identifier registers behind the serial management pins
module pst_status_regs #(
  parameter logic [15:0] ID_HI_DEFAULT = 16'h5a5a, // arbitrary value
  parameter logic [15:0] ID_LO_DEFAULT = 16'h3c3c  // arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [4:0] phy_addr,
  input  wire logic       override_en,
  input  wire logic       jabber_en,
  input  wire logic       an_enable,
  input  wire logic       an_complete,
  input  wire logic       lcw_valid,
  input  wire logic       lcw_rfault,
  input  wire logic       link_valid,
  input  wire logic       jabber_det,
  output logic            pre_sup_en,
  output logic [3:0]      test_bits
);

  // synchronised pins
  logic [6:0] pin_q;
  logic       mdc_q;
  logic       mdio_q;
  logic [4:0] addr_q;

  pst_sync #(
    .WIDTH (7)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({phy_addr, mdio_in, mdc}),
    .dout    (pin_q)
  );

  assign mdc_q  = pin_q[0];
  assign mdio_q = pin_q[1];
  assign addr_q = pin_q[6:2];

  // frame engine state
  pst_pkg::pst_state_type state_reg;
  logic        mdc_prev_reg;
  logic [5:0]  pre_cnt_reg;
  logic [4:0]  bit_cnt_reg;
  logic [11:0] hdr_reg;
  logic [15:0] data_reg;
  logic        rd_hit_reg;
  logic        wr_hit_reg;
  logic        wr_stb_reg;
  logic [4:0]  wr_addr_reg;
  logic [15:0] wr_data_reg;
  logic        clr_reg;

  // register contents
  logic        an_done_reg;
  logic        rf_latch_reg;
  logic        rf_copy_reg;
  logic        link_lat_reg;
  logic        jab_reg;
  logic [15:0] id_hi_reg;
  logic [15:0] id_lo_reg;

  logic        mdc_rise;
  logic        mdc_fall;
  logic [11:0] hdr_next;
  logic [4:0]  hdr_reg_addr;
  logic        hdr_match;
  logic        pre_ok;

  // management clock edges from the synchronised copy
  assign mdc_rise = mdc_q & ~mdc_prev_reg;
  assign mdc_fall = ~mdc_q & mdc_prev_reg;

  // header as it stands after the current bit
  assign hdr_next     = {hdr_reg[10:0], mdio_q};
  assign hdr_reg_addr = hdr_next[4:0];
  assign hdr_match    = (hdr_next[9:5] == addr_q);

  // preamble may be skipped once suppression is enabled
  assign pre_ok = (pre_cnt_reg >= `PST_PREAMBLE_BITS) || pre_sup_en;

  // read value of a management register
  function automatic logic [15:0] read_word(input logic [4:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    unique case (addr)
      `PST_ADDR_STATUS: begin
        w[`PST_BIT_PRE_SUP] = pre_sup_en;
        w[`PST_BIT_AN_DONE] = an_done_reg;
        w[`PST_BIT_RFAULT]  = rf_latch_reg;
        w[`PST_BIT_AN_ABLE] = 1'b1;
        w[`PST_BIT_LINK]    = link_lat_reg;
        w[`PST_BIT_JABBER]  = jab_reg;
        w[`PST_BIT_EXT_CAP] = 1'b1;
        // reserved bits stay zero on read
      end
      `PST_ADDR_ID_HI: begin
        w = id_hi_reg;
      end
      `PST_ADDR_ID_LO: begin
        w = id_lo_reg;
      end
      `PST_ADDR_LP_ABIL: begin
        w[`PST_BIT_LP_RFAULT] = rf_copy_reg;
      end
      `PST_ADDR_FAST_STAT: begin
        w[`PST_BIT_FS_JABBER] = jab_reg;
        w[`PST_BIT_FS_RFAULT] = rf_latch_reg;
        w[`PST_BIT_FS_LINK]   = link_lat_reg;
      end
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // management clock edge history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_prev_reg <= 1'b0;
    end else begin
      mdc_prev_reg <= mdc_q;
    end
  end

  // frame receiver: preamble, start, header, turnaround, data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= pst_pkg::ST_IDLE;
      pre_cnt_reg <= 6'd0;
      bit_cnt_reg <= 5'd0;
      hdr_reg     <= 12'h000;
      data_reg    <= 16'h0000;
      rd_hit_reg  <= 1'b0;
      wr_hit_reg  <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_addr_reg <= 5'h00;
      wr_data_reg <= 16'h0000;
      clr_reg     <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      clr_reg    <= 1'b0;
      if (mdc_rise) begin
        unique case (state_reg)
          pst_pkg::ST_IDLE: begin
            if (mdio_q) begin
              if (pre_cnt_reg < `PST_PREAMBLE_BITS) begin
                pre_cnt_reg <= pre_cnt_reg + 6'd1;
              end
            end else begin
              if (pre_ok) begin
                state_reg <= pst_pkg::ST_START;
              end
              pre_cnt_reg <= 6'd0;
            end
          end
          pst_pkg::ST_START: begin
            bit_cnt_reg <= 5'd0;
            state_reg   <= mdio_q ? pst_pkg::ST_HDR : pst_pkg::ST_IDLE;
          end
          pst_pkg::ST_HDR: begin
            hdr_reg     <= hdr_next;
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == `PST_HDR_LAST) begin
              bit_cnt_reg <= 5'd0;
              rd_hit_reg  <= hdr_match && (hdr_next[11:10] == `PST_OP_READ);
              wr_hit_reg  <= hdr_match && (hdr_next[11:10] == `PST_OP_WRITE);
              if (hdr_next[11:10] == `PST_OP_READ ||
                  hdr_next[11:10] == `PST_OP_WRITE) begin
                state_reg <= pst_pkg::ST_TA;
              end else begin
                state_reg <= pst_pkg::ST_IDLE;
              end
              // snapshot, then release latches of a register being read
              if (hdr_match && hdr_next[11:10] == `PST_OP_READ) begin
                data_reg <= read_word(hdr_reg_addr);
                clr_reg  <= (hdr_reg_addr == `PST_ADDR_STATUS) ||
                            (hdr_reg_addr == `PST_ADDR_FAST_STAT);
              end
            end
          end
          pst_pkg::ST_TA: begin
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (bit_cnt_reg == `PST_TA_LAST) begin
              bit_cnt_reg <= 5'd0;
              state_reg   <= pst_pkg::ST_DATA;
            end
          end
          pst_pkg::ST_DATA: begin
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
            if (!rd_hit_reg) begin
              data_reg <= {data_reg[14:0], mdio_q};
            end
            if (bit_cnt_reg == `PST_DATA_LAST) begin
              bit_cnt_reg <= 5'd0;
              state_reg   <= pst_pkg::ST_IDLE;
              wr_stb_reg  <= wr_hit_reg;
              wr_addr_reg <= hdr_reg[4:0];
              wr_data_reg <= {data_reg[14:0], mdio_q};
              rd_hit_reg  <= 1'b0;
              wr_hit_reg  <= 1'b0;
            end
          end
        endcase
      end else if (mdc_fall && state_reg == pst_pkg::ST_DATA && rd_hit_reg) begin
        data_reg <= {data_reg[14:0], 1'b0};
      end
    end
  end

  // read data driven out after each falling management clock edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end else if (mdc_fall) begin
      if (rd_hit_reg && state_reg == pst_pkg::ST_TA && bit_cnt_reg == `PST_TA_LAST) begin
        mdio_out <= 1'b0; // turnaround zero
        mdio_oe  <= 1'b1;
      end else if (rd_hit_reg && state_reg == pst_pkg::ST_DATA) begin
        mdio_out <= data_reg[15];
        mdio_oe  <= 1'b1;
      end else begin
        mdio_out <= 1'b0;
        mdio_oe  <= 1'b0;
      end
    end
  end

  // gated writes to status bits 1.10:6
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_sup_en <= `PST_RST_PRE_SUP;
      test_bits  <= `PST_RST_RESV;
    end else if (wr_stb_reg && override_en &&
                 wr_addr_reg == `PST_ADDR_STATUS) begin
      pre_sup_en <= wr_data_reg[`PST_BIT_PRE_SUP];
      test_bits  <= wr_data_reg[`PST_BIT_RESV_HI:`PST_BIT_RESV_LO];
    end
  end

  // identifier registers, gated by override enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      id_hi_reg <= ID_HI_DEFAULT;
      id_lo_reg <= ID_LO_DEFAULT;
    end else if (wr_stb_reg && override_en) begin
      if (wr_addr_reg == `PST_ADDR_ID_HI) begin
        id_hi_reg <= wr_data_reg;
      end
      if (wr_addr_reg == `PST_ADDR_ID_LO) begin
        id_lo_reg <= wr_data_reg;
      end
    end
  end

  // negotiation complete, latched high, forced low when disabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      an_done_reg <= 1'b0;
    end else if (!an_enable) begin
      an_done_reg <= 1'b0;
    end else begin
      an_done_reg <= an_complete | (an_done_reg & ~clr_reg);
    end
  end

  // remote fault: latched copy and plain copy from each code word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rf_latch_reg <= 1'b0;
      rf_copy_reg  <= 1'b0;
    end else begin
      if (lcw_valid) begin
        rf_copy_reg <= lcw_rfault;
      end
      if (lcw_valid && lcw_rfault) begin
        rf_latch_reg <= 1'b1;
      end else if (clr_reg) begin
        rf_latch_reg <= lcw_valid ? 1'b0 : rf_copy_reg;
      end
    end
  end

  // link status, latched low until read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_lat_reg <= 1'b0;
    end else begin
      link_lat_reg <= link_valid & (link_lat_reg | clr_reg);
    end
  end

  // jabber detect, latched high, off when detection inhibited
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      jab_reg <= 1'b0;
    end else if (!jabber_en) begin
      jab_reg <= 1'b0;
    end else begin
      jab_reg <= jabber_det | (jab_reg & ~clr_reg);
    end
  end

  // checks
  a_resv_read_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_reg == pst_pkg::ST_HDR && mdc_rise && bit_cnt_reg == `PST_HDR_LAST &&
     hdr_match && hdr_next[11:10] == `PST_OP_READ &&
     hdr_reg_addr == `PST_ADDR_STATUS)
    |=> (data_reg[10:7] == 4'h0 && data_reg[3] && data_reg[0]))
    else $error("status read shows bad fixed bits");

  a_gated_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    (wr_stb_reg && !override_en) |=> ($stable(id_hi_reg) && $stable(id_lo_reg) &&
                                      $stable(pre_sup_en) && $stable(test_bits)))
    else $error("gated write changed a register");

  a_an_off_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    !an_enable |=> !an_done_reg)
    else $error("negotiation complete set while disabled");

  a_an_latch_keep: assert property (
    @(posedge clk) disable iff (sys_rst)
    (an_done_reg && an_enable && !clr_reg) ##1 an_enable |-> an_done_reg)
    else $error("negotiation complete lost without read");

  a_read_release: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clr_reg && an_enable && !an_complete) |=> !an_done_reg)
    else $error("read did not release complete flag");

  a_rf_code_word: assert property (
    @(posedge clk) disable iff (sys_rst)
    (lcw_valid && lcw_rfault) |=> (rf_latch_reg && rf_copy_reg))
    else $error("remote fault not taken from code word");

  a_rf_plain_copy: assert property (
    @(posedge clk) disable iff (sys_rst)
    (lcw_valid && !lcw_rfault) |=> !rf_copy_reg)
    else $error("plain remote fault copy not refreshed");

  a_link_drop: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!link_valid ##1 (link_valid && !clr_reg)) |=> !link_lat_reg)
    else $error("link drop not held until read");

  a_jab_off: assert property (
    @(posedge clk) disable iff (sys_rst)
    !jabber_en |=> !jab_reg)
    else $error("jabber flag set while inhibited");

  a_jab_set: assert property (
    @(posedge clk) disable iff (sys_rst)
    (jabber_en && jabber_det) |=> jab_reg)
    else $error("jabber event not latched");

  a_jab_clear: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clr_reg && !jabber_det) |=> !jab_reg)
    else $error("jabber flag not cleared by read");

endmodule // pst_status_regs

// file: tb/pst_sta_model.sv
`timescale 1ns/100ps

// station management model: makes mdc and drives the master side of mdio
module pst_sta_model (
  input  wire logic clk,
  output logic      mdc,
  output logic      sta_dat,
  output logic      sta_en,
  input  wire logic mdio
);
  logic smp;

  // mdc stands high and mdio released between frames
  initial begin
    mdc = 1'h1;
    sta_dat = 1'h1;
    sta_en = 1'h0;
  end

  // one mdc period: data set in low phase, wire sampled at end of high phase
  task automatic bit_cyc(input logic b, input logic en);
    @(negedge clk);
    mdc = 1'h0;
    sta_dat = b;
    sta_en = en;
    repeat (5) @(negedge clk);
    mdc = 1'h1;
    repeat (5) @(negedge clk);
    smp = mdio;
  endtask

  // whole frame; the caller supplies every data bit, reserved ones included
  task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, input logic pre, output logic [15:0] q);
    logic [13:0] hdr;
    hdr = {2'h1, rd ? 2'h2 : 2'h1, pa, ra};
    if (pre) begin
      repeat (32) bit_cyc(1'h1, 1'h1);
    end
    for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'h1);
    // turnaround: driven 1 0 on writes, released on reads
    bit_cyc(1'h1, !rd);
    bit_cyc(1'h0, !rd);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wd[i], !rd);
      q[i] = smp;
    end
    bit_cyc(1'h1, 1'h0); // trailing fall lets the device release the line
  endtask
endmodule // pst_sta_model

// file: tb/tb_top.sv
`timescale 1ns/100ps
`include "pst_regs.svh"

module tb_top;
  logic        clk, sys_rst, mdc, mdio_out, mdio_oe, sta_dat, sta_en, mdio_w;
  logic        override_en, jabber_en, an_enable, an_complete, lcw_valid;
  logic        lcw_rfault, link_valid, jabber_det, pre_sup_en, ps;
  logic [3:0]  test_bits;
  logic [4:0]  pa;
  logic [15:0] q;
  int          fail_count;
  int          samples_checked;

  // identifier values handed to the design, arbitrary
  localparam logic [15:0] ID_HI_EXP = 16'h1e2d;
  localparam logic [15:0] ID_LO_EXP = 16'h4b69;

  // mdio has a pull-up: released by both parties it reads high
  assign mdio_w = mdio_oe ? mdio_out : (sta_en ? sta_dat : 1'h1);

  pst_status_regs #(
    .ID_HI_DEFAULT (ID_HI_EXP),
    .ID_LO_DEFAULT (ID_LO_EXP)
  ) uut (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .mdc         (mdc),
    .mdio_in     (mdio_w),
    .mdio_out    (mdio_out),
    .mdio_oe     (mdio_oe),
    .phy_addr    (pa),
    .override_en (override_en),
    .jabber_en   (jabber_en),
    .an_enable   (an_enable),
    .an_complete (an_complete),
    .lcw_valid   (lcw_valid),
    .lcw_rfault  (lcw_rfault),
    .link_valid  (link_valid),
    .jabber_det  (jabber_det),
    .pre_sup_en  (pre_sup_en),
    .test_bits   (test_bits)
  );

  pst_sta_model sta (
    .clk     (clk),
    .mdc     (mdc),
    .sta_dat (sta_dat),
    .sta_en  (sta_en),
    .mdio    (mdio_w)
  );

  // expected status word from {an_done, rfault, link, jabber}
  function automatic logic [15:0] st1(input logic [3:0] f);
    return {9'h000, ps, f[3:2], 1'h1, f[1:0], 1'h1};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    sta.xfer(1'h1, pa, ra, 16'h0000, 1'h1, v);
    check(v, exp);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] v;
    sta.xfer(1'h0, pa, ra, d, 1'h1, v);
  endtask

  task automatic test_done;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // 20 ns clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // watchdog, about twice the expected run
  initial begin
    #1000000;
    fail_count++;
    test_done;
  end

  // main sequence
  initial begin
    fail_count = 0;
    samples_checked = 0;
    {override_en, jabber_en, an_enable, an_complete, lcw_valid} = 5'h00;
    {lcw_rfault, jabber_det, ps} = 3'h0;
    link_valid = 1'h1;
    pa = 5'h07;
    sys_rst = 1'h1;
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    repeat (5) @(negedge clk);
    rd(`PST_ADDR_STATUS, st1(4'h0));
    rd(`PST_ADDR_STATUS, st1(4'h2));
    check({11'h000, pre_sup_en, test_bits}, 16'h0000);
    rd(`PST_ADDR_ID_HI, ID_HI_EXP);
    rd(`PST_ADDR_ID_LO, ID_LO_EXP);
    // gated writes refused while override is off
    wr(`PST_ADDR_ID_HI, 16'h8001);
    wr(`PST_ADDR_ID_LO, 16'h1234);
    wr(`PST_ADDR_STATUS, 16'h07c0);
    rd(`PST_ADDR_ID_HI, ID_HI_EXP);
    rd(`PST_ADDR_ID_LO, ID_LO_EXP);
    check({11'h000, pre_sup_en, test_bits}, 16'h0000);
    @(negedge clk) override_en = 1'h1;
    wr(`PST_ADDR_ID_HI, 16'h8001);
    rd(`PST_ADDR_ID_HI, 16'h8001);
    wr(`PST_ADDR_ID_LO, 16'h1234);
    rd(`PST_ADDR_ID_LO, 16'h1234);
    wr(`PST_ADDR_STATUS, 16'h0780);
    check({11'h000, pre_sup_en, test_bits}, 16'h000f);
    rd(`PST_ADDR_STATUS, st1(4'h2));
    wr(`PST_ADDR_STATUS, 16'h0040);
    ps = 1'h1;
    check({11'h000, pre_sup_en, test_bits}, 16'h0010);
    @(negedge clk) override_en = 1'h0;
    sta.xfer(1'h1, pa, `PST_ADDR_STATUS, 16'h0000, 1'h0, q);
    check(q, st1(4'h2));
    // negotiation complete, disabled then enabled
    @(negedge clk) an_complete = 1'h1;
    @(negedge clk) an_complete = 1'h0;
    rd(`PST_ADDR_STATUS, st1(4'h2));
    @(negedge clk) an_enable = 1'h1;
    @(negedge clk) an_complete = 1'h1;
    @(negedge clk) an_complete = 1'h0;
    rd(`PST_ADDR_STATUS, st1(4'ha));
    rd(`PST_ADDR_STATUS, st1(4'h2));
    // remote fault from code words
    @(negedge clk) {lcw_valid, lcw_rfault} = 2'h3;
    @(negedge clk) {lcw_valid, lcw_rfault} = 2'h0;
    rd(`PST_ADDR_LP_ABIL, 16'h2000);
    @(negedge clk) lcw_valid = 1'h1;
    @(negedge clk) lcw_valid = 1'h0;
    rd(`PST_ADDR_LP_ABIL, 16'h0000);
    rd(`PST_ADDR_FAST_STAT, 16'h0003);
    rd(`PST_ADDR_STATUS, st1(4'h2));
    // jabber, inhibited then enabled
    @(negedge clk) jabber_det = 1'h1;
    @(negedge clk) jabber_det = 1'h0;
    rd(`PST_ADDR_FAST_STAT, 16'h0001);
    @(negedge clk) jabber_en = 1'h1;
    @(negedge clk) jabber_det = 1'h1;
    @(negedge clk) jabber_det = 1'h0;
    rd(`PST_ADDR_STATUS, st1(4'h3));
    rd(`PST_ADDR_FAST_STAT, 16'h0001);
    // momentary link drop
    @(negedge clk) link_valid = 1'h0;
    @(negedge clk) link_valid = 1'h1;
    rd(`PST_ADDR_FAST_STAT, 16'h0000);
    rd(`PST_ADDR_STATUS, st1(4'h2));
    // mid-run reset brings back every default
    @(negedge clk) sys_rst = 1'h1;
    ps = 1'h0;
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    repeat (5) @(negedge clk);
    check({11'h000, pre_sup_en, test_bits}, 16'h0000);
    rd(`PST_ADDR_ID_HI, ID_HI_EXP);
    rd(`PST_ADDR_ID_LO, ID_LO_EXP);
    rd(`PST_ADDR_STATUS, st1(4'h0));
    // foreign device address and unmapped register
    sta.xfer(1'h1, pa ^ 5'h01, `PST_ADDR_STATUS, 16'h0000, 1'h1, q);
    check(q, 16'hffff);
    rd(5'h1f, 16'h0000);
    test_done;
  end
endmodule // tb_top
